// File: rtl/rbag_map.vh
`ifndef RBAG_MAP_VH
`define RBAG_MAP_VH

// register byte offsets
`define RBAG_OFS_CTRL 8'h00
`define RBAG_OFS_POINTER 8'h04
`define RBAG_OFS_AUXZERO 8'h08
`define RBAG_OFS_TEMPIDX 8'h0c
`define RBAG_OFS_BUFSTART 8'h10
`define RBAG_OFS_ACC 8'h14
`define RBAG_OFS_CMD 8'h18
`define RBAG_OFS_STATUS0 8'h1c
`define RBAG_OFS_LASTADDR 8'h20

// control fields
`define RBAG_CTRL_LEGACY 0
`define RBAG_CTRL_CIRC 1

// command fields
`define RBAG_CMD_FORM_LO 0
`define RBAG_CMD_FORM_HI 1
`define RBAG_CMD_OP_LO 2
`define RBAG_CMD_OP_HI 3
`define RBAG_CMD_START 8

// status fields
`define RBAG_ST_TEST1 0
`define RBAG_ST_TEST2 1
`define RBAG_ST_BUSY 0

// operand forms
`define RBAG_FORM_POSTDEC 2'h0
`define RBAG_FORM_INDEXED 2'h1
`define RBAG_FORM_BRINC 2'h2
`define RBAG_FORM_BRDEC 2'h3

// bit operations
`define RBAG_OP_SET 2'h0
`define RBAG_OP_CLEAR 2'h1
`define RBAG_OP_TEST 2'h2
`define RBAG_OP_TESTPAIR 2'h3

// reset values
`define RBAG_RST_WORD 32'h00000000

`endif

// File: rtl/rbag_bitrev_addsub.v
`timescale 1ns/10ps
module rbag_bitrev_addsub #(
    parameter W = 16
) (
    // operands
    input wire [W-1:0] a_i,
    input wire [W-1:0] b_i,
    input wire sub_i,
    // result
    output wire [W-1:0] y_o
);
    wire [W-1:0] a_rev;
    wire [W-1:0] b_rev;
    wire [W-1:0] y_rev;
    genvar g;
    // carries run from msb toward lsb by mirroring the operands
    generate
        for (g = 0; g < W; g = g + 1) begin : g_rev
            assign a_rev[g] = a_i[W-1-g];
            assign b_rev[g] = b_i[W-1-g];
            assign y_o[g] = y_rev[W-1-g];
        end
    endgenerate
    assign y_rev = sub_i ? (a_rev - b_rev) : (a_rev + b_rev);
endmodule // rbag_bitrev_addsub

// File: rtl/rbag_ahb_slave.v
`timescale 1ns/10ps
module rbag_ahb_slave (
    // clock and reset
    input wire clk_sys_i,
    input wire srst_i,
    // ahb-lite slave side
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // register file side
    output wire [7:0] rd_addr_o,
    input wire [31:0] rd_data_i,
    output wire wr_en_o,
    output wire [7:0] wr_addr_o,
    output wire [31:0] wr_data_o
);
    reg wr_pend_q;
    reg rd_retry_q;
    reg [7:0] addr_q;
    wire take;
    wire take_rd;
    wire take_wr;

    assign take = hsel_i && htrans_i[1] && hready_i;
    assign take_rd = take && !hwrite_i;
    assign take_wr = take && hwrite_i;
    assign rd_addr_o = rd_retry_q ? addr_q : haddr_i;
    assign wr_en_o = wr_pend_q;
    assign wr_addr_o = addr_q;
    assign wr_data_o = hwdata_i;

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_pend_q <= 1'b0;
            rd_retry_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hresp_o <= 1'b0;
            wr_pend_q <= take_wr;
            if (rd_retry_q) begin
                // stalled read now sees the committed write
                rd_retry_q <= 1'b0;
                hrdata_o <= rd_data_i;
                hreadyout_o <= 1'b1;
            end else if (take_rd && wr_pend_q) begin
                rd_retry_q <= 1'b1;
                addr_q <= haddr_i;
                hreadyout_o <= 1'b0;
            end else begin
                hreadyout_o <= 1'b1;
                if (take_rd) begin
                    hrdata_o <= rd_data_i;
                end
                if (take) begin
                    addr_q <= haddr_i;
                end
            end
        end
    end
endmodule // rbag_ahb_slave

// File: rtl/rbag_top.v
// How it works
// - post-decrement form: address pointer, then subtract index
// - indexed form: pointer plus index, pointer kept
// - legacy mode picks aux pointer zero as index
// - pair test addresses bit and bit plus one
// - pair test copies lower, upper bits into flags
// - set touches only the addressed accumulator bit
// - bitrev increment: address pointer, reverse-carry add
// - bitrev decrement: address pointer, reverse-carry subtract
// - circular mode: every form adds buffer start, bitrev pointer kept
// - pair test updates pointer once, after both bits
`timescale 1ns/10ps
`include "rbag_map.vh"
module rbag_top #(
    parameter PW = 16,
    parameter AW = 32
) (
    // clock and reset
    input wire clk_sys_i,
    input wire srst_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    // status
    output reg busy_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_BIT_A = 2'd1;
    localparam ST_BIT_B = 2'd2;
    localparam ST_UPD = 2'd3;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg legacy_compat_mode_q;
    reg circ_en_q;
    reg [PW-1:0] aux_pointer_n_q;
    reg [PW-1:0] aux_pointer_n_d;
    reg [PW-1:0] aux_pointer_zero_q;
    reg [PW-1:0] temp_index_zero_q;
    reg [PW-1:0] buffer_start_value_q;
    reg [AW-1:0] accumulator_three_q;
    reg [AW-1:0] accumulator_three_d;
    reg test_flag_one_q;
    reg test_flag_one_d;
    reg test_flag_two_q;
    reg test_flag_two_d;
    reg [1:0] form_q;
    reg [1:0] op_q;
    reg [PW-1:0] eaddr_q;
    reg [PW-1:0] eaddr_d;
    reg [PW-1:0] last_addr_q;
    reg [PW-1:0] last_addr_d;
    reg [31:0] rd_data;

    wire [7:0] rd_addr;
    wire wr_en;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [PW-1:0] index_sel;
    wire [PW-1:0] circ_base;
    wire [PW-1:0] cmd_eaddr;
    wire [PW-1:0] br_result;
    wire [PW-1:0] pair_addr;
    wire [1:0] cmd_form;
    wire [1:0] cmd_op;
    wire cmd_start;
    wire sw_wr;

    // bus front end
    rbag_ahb_slave u_bus (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data)
    );

    // reverse-carry pointer update
    rbag_bitrev_addsub #(
        .W(PW)
    ) u_brev (
        .a_i(aux_pointer_n_q),
        .b_i(index_sel),
        .sub_i(form_q == `RBAG_FORM_BRDEC),
        .y_o(br_result)
    );

    // accumulator bit picked by the low address bits
    function bit_of;
        input [AW-1:0] acc;
        input [PW-1:0] addr;
        begin
            bit_of = acc[addr[4:0]];
        end
    endfunction

    // one-hot mask of the addressed accumulator bit
    function [AW-1:0] mask_of;
        input [PW-1:0] addr;
        begin
            mask_of = {{(AW-1){1'b0}}, 1'b1} << addr[4:0];
        end
    endfunction

    assign index_sel = legacy_compat_mode_q ? aux_pointer_zero_q : temp_index_zero_q;
    assign circ_base = circ_en_q ? buffer_start_value_q : {PW{1'b0}};
    assign cmd_form = wr_data[`RBAG_CMD_FORM_HI:`RBAG_CMD_FORM_LO];
    assign cmd_op = wr_data[`RBAG_CMD_OP_HI:`RBAG_CMD_OP_LO];
    assign cmd_start = wr_en && (wr_addr == `RBAG_OFS_CMD) && wr_data[`RBAG_CMD_START];
    assign sw_wr = wr_en && (state_q == ST_IDLE);
    // indexed form adds the offset, the others use the pointer alone; both add circ_base
    assign cmd_eaddr = (cmd_form == `RBAG_FORM_INDEXED) ?
        (circ_base + aux_pointer_n_q + index_sel) :
        (circ_base + aux_pointer_n_q);
    assign pair_addr = eaddr_q + {{(PW-1){1'b0}}, 1'b1};

    // register read mux
    always @* begin
        rd_data = `RBAG_RST_WORD;
        case (rd_addr)
            `RBAG_OFS_CTRL: begin
                rd_data[`RBAG_CTRL_LEGACY] = legacy_compat_mode_q;
                rd_data[`RBAG_CTRL_CIRC] = circ_en_q;
            end
            `RBAG_OFS_POINTER: rd_data[PW-1:0] = aux_pointer_n_q;
            `RBAG_OFS_AUXZERO: rd_data[PW-1:0] = aux_pointer_zero_q;
            `RBAG_OFS_TEMPIDX: rd_data[PW-1:0] = temp_index_zero_q;
            `RBAG_OFS_BUFSTART: rd_data[PW-1:0] = buffer_start_value_q;
            `RBAG_OFS_ACC: rd_data[AW-1:0] = accumulator_three_q;
            `RBAG_OFS_CMD: rd_data[`RBAG_ST_BUSY] = busy_o;
            `RBAG_OFS_STATUS0: begin
                rd_data[`RBAG_ST_TEST1] = test_flag_one_q;
                rd_data[`RBAG_ST_TEST2] = test_flag_two_q;
            end
            `RBAG_OFS_LASTADDR: rd_data[PW-1:0] = last_addr_q;
            default: rd_data = `RBAG_RST_WORD;
        endcase
    end

    // sequencer and datapath next state
    always @* begin
        state_d = state_q;
        eaddr_d = eaddr_q;
        last_addr_d = last_addr_q;
        aux_pointer_n_d = aux_pointer_n_q;
        accumulator_three_d = accumulator_three_q;
        test_flag_one_d = test_flag_one_q;
        test_flag_two_d = test_flag_two_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_start) begin
                    eaddr_d = cmd_eaddr;
                    state_d = ST_BIT_A;
                end
            end
            ST_BIT_A: begin
                last_addr_d = eaddr_q;
                case (op_q)
                    `RBAG_OP_SET: begin
                        accumulator_three_d = accumulator_three_q | mask_of(eaddr_q);
                    end
                    `RBAG_OP_CLEAR: begin
                        accumulator_three_d = accumulator_three_q & ~mask_of(eaddr_q);
                    end
                    `RBAG_OP_TEST: begin
                        test_flag_one_d = bit_of(accumulator_three_q, eaddr_q);
                    end
                    default: begin
                        test_flag_one_d = bit_of(accumulator_three_q, eaddr_q);
                    end
                endcase
                state_d = (op_q == `RBAG_OP_TESTPAIR) ? ST_BIT_B : ST_UPD;
            end
            ST_BIT_B: begin
                last_addr_d = pair_addr;
                test_flag_two_d = bit_of(accumulator_three_q, pair_addr);
                state_d = ST_UPD;
            end
            ST_UPD: begin
                // single pointer update after all bit accesses
                case (form_q)
                    `RBAG_FORM_POSTDEC: begin
                        aux_pointer_n_d = aux_pointer_n_q - index_sel;
                    end
                    `RBAG_FORM_INDEXED: begin
                        aux_pointer_n_d = aux_pointer_n_q;
                    end
                    default: begin
                        // circular pointers stay put under bitrev forms
                        if (!circ_en_q) begin
                            aux_pointer_n_d = br_result;
                        end else begin
                            aux_pointer_n_d = aux_pointer_n_q;
                        end
                    end
                endcase
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            busy_o <= 1'b0;
            legacy_compat_mode_q <= 1'b0;
            circ_en_q <= 1'b0;
            aux_pointer_n_q <= {PW{1'b0}};
            aux_pointer_zero_q <= {PW{1'b0}};
            temp_index_zero_q <= {PW{1'b0}};
            buffer_start_value_q <= {PW{1'b0}};
            accumulator_three_q <= {AW{1'b0}};
            test_flag_one_q <= 1'b0;
            test_flag_two_q <= 1'b0;
            form_q <= 2'h0;
            op_q <= 2'h0;
            eaddr_q <= {PW{1'b0}};
            last_addr_q <= {PW{1'b0}};
        end else begin
            state_q <= state_d;
            busy_o <= (state_d != ST_IDLE);
            eaddr_q <= eaddr_d;
            last_addr_q <= last_addr_d;
            aux_pointer_n_q <= aux_pointer_n_d;
            accumulator_three_q <= accumulator_three_d;
            test_flag_one_q <= test_flag_one_d;
            test_flag_two_q <= test_flag_two_d;
            if (state_q == ST_IDLE && cmd_start) begin
                form_q <= cmd_form;
                op_q <= cmd_op;
            end
            // software writes only land while idle
            if (sw_wr) begin
                case (wr_addr)
                    `RBAG_OFS_CTRL: begin
                        legacy_compat_mode_q <= wr_data[`RBAG_CTRL_LEGACY];
                        circ_en_q <= wr_data[`RBAG_CTRL_CIRC];
                    end
                    `RBAG_OFS_POINTER: aux_pointer_n_q <= wr_data[PW-1:0];
                    `RBAG_OFS_AUXZERO: aux_pointer_zero_q <= wr_data[PW-1:0];
                    `RBAG_OFS_TEMPIDX: temp_index_zero_q <= wr_data[PW-1:0];
                    `RBAG_OFS_BUFSTART: buffer_start_value_q <= wr_data[PW-1:0];
                    `RBAG_OFS_ACC: accumulator_three_q <= wr_data[AW-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // rbag_top

// File: tb/rbag_top_sva.sv
`timescale 1ns/10ps
`include "rbag_map.vh"
module rbag_top_sva (
    // clock and reset
    input wire clk_sys_i,
    input wire srst_i,
    // bus
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    input wire [31:0] hrdata_o,
    input wire hreadyout_o,
    input wire hresp_o,
    // status
    input wire busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    reg wr_q;
    reg cmd_q;
    wire take = hsel_i && htrans_i[1] && hready_i;
    wire go = cmd_q && hready_i && hwdata_i[`RBAG_CMD_START] && !busy_o;
    // data phase trackers
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_q <= 1'b0;
            cmd_q <= 1'b0;
        end else if (hready_i) begin
            wr_q <= take && hwrite_i;
            cmd_q <= take && hwrite_i && haddr_i == `RBAG_OFS_CMD;
        end
    end
    property p_resp_okay;
        hresp_o == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("error response seen");
    property p_single;
        go && hwdata_i[3:2] != 2'h3 |=> busy_o [*2] ##1 !busy_o;
    endproperty
    a_single: assert property (p_single) else $error("single op busy length");
    property p_pair;
        go && hwdata_i[3:2] == 2'h3 |=> busy_o [*3] ##1 !busy_o;
    endproperty
    a_pair: assert property (p_pair) else $error("pair op busy length");
    property p_busy_cause;
        $rose(busy_o) |-> $past(go);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
    property p_wait_one;
        !hreadyout_o |=> hreadyout_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait state too long");
    property p_wait_cause;
        $fell(hreadyout_o) |-> $past(wr_q);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("wait state without write");
    property p_read_fast;
        take && !hwrite_i && !wr_q |=> hreadyout_o;
    endproperty
    a_read_fast: assert property (p_read_fast) else $error("read stalled");
    property p_busy_min;
        $fell(busy_o) |-> $past(busy_o, 2);
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    c_pair: cover property (go && hwdata_i[3:2] == 2'h3);
    c_wait: cover property (!hreadyout_o);
    c_done: cover property ($fell(busy_o));
endmodule // rbag_top_sva
bind rbag_top rbag_top_sva u_sva (.clk_sys_i, .srst_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .busy_o);

// File: tb/rbag_host_model.sv
`timescale 1ns/10ps
module rbag_host_model (
    // clock
    input wire clk_sys_i,
    // request side
    input wire req_i,
    input wire wr_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    output reg ack_o = 1'b0,
    output reg [31:0] rdata_o = 32'h0,
    // ahb-lite master
    output wire hsel_o,
    output reg [7:0] haddr_o = 8'h0,
    output reg [1:0] htrans_o = 2'h0,
    output reg hwrite_o = 1'b0,
    output wire [2:0] hsize_o,
    output reg [31:0] hwdata_o = 32'h0,
    input wire hready_i,
    input wire [31:0] hrdata_i
);
    reg [1:0] st_q = 2'h0;
    assign hsel_o = 1'b1;
    assign hsize_o = 3'h2;
    // address phase, data phase, then ack
    always @(posedge clk_sys_i) begin
        ack_o <= 1'b0;
        if (st_q == 2'h0 && req_i && !ack_o) begin
            htrans_o <= 2'h2;
            haddr_o <= addr_i;
            hwrite_o <= wr_i;
            st_q <= 2'h1;
        end else if (st_q == 2'h1 && hready_i) begin
            htrans_o <= 2'h0;
            hwdata_o <= wdata_i;
            st_q <= 2'h2;
        end else if (st_q == 2'h2 && hready_i) begin
            rdata_o <= hrdata_i;
            ack_o <= 1'b1;
            st_q <= 2'h0;
        end else if (st_q == 2'h0) begin
            hwdata_o <= ~hwdata_o;
        end
    end
endmodule // rbag_host_model

// File: tb/tb_register_bit_address_generator.sv
`timescale 1ns/10ps
`include "rbag_map.vh"
module tb_register_bit_address_generator;
    reg clk_sys_i = 1'b0;
    reg srst_i = 1'b1;
    reg req = 1'b0;
    reg wr = 1'b0;
    reg [7:0] addr = 8'h0;
    reg [31:0] wdata = 32'h0;
    reg [31:0] rd;
    wire ack, hsel, hwrite, hready, hresp, busy;
    wire [7:0] haddr;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [31:0] hwdata, hrdata, rdata;
    integer failures = 0;
    integer total_checks = 0;
    integer a;
    initial forever #4 clk_sys_i = ~clk_sys_i;
    rbag_host_model u_host (.clk_sys_i(clk_sys_i), .req_i(req), .wr_i(wr), .addr_i(addr),
        .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata), .hsel_o(hsel), .haddr_o(haddr),
        .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
        .hready_i(hready), .hrdata_i(hrdata));
    rbag_top u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .busy_o(busy));
    task summarize;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // reverse carry: mirror, add or subtract, mirror back
    function [15:0] rc(input [15:0] x, input [15:0] y, input s);
        reg [15:0] mx, my, r;
        integer i;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                mx[i] = x[15-i];
                my[i] = y[15-i];
            end
            r = s ? mx - my : mx + my;
            for (i = 0; i < 16; i = i + 1) rc[i] = r[15-i];
        end
    endfunction
    task bus(input w, input [7:0] ad, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys_i);
            req <= 1'b1;
            wr <= w;
            addr <= ad;
            wdata <= d;
            n = 0;
            do begin
                @(posedge clk_sys_i);
                #1 n = n + 1;
            end while (ack !== 1'b1 && n < 50);
            if (ack !== 1'b1) begin
                failures = failures + 1;
                summarize;
            end
            rd = rdata;
            @(posedge clk_sys_i);
            req <= 1'b0;
        end
    endtask
    task rchk(input [7:0] ad, input [31:0] e);
        begin
            bus(1'b0, ad, 32'h0);
            chk(rd, e);
        end
    endtask
    task regs(input [31:0] c, input [31:0] p, input [31:0] x, input [31:0] t,
              input [31:0] b, input [31:0] q);
        begin
            bus(1'b1, `RBAG_OFS_CTRL, c);
            bus(1'b1, `RBAG_OFS_POINTER, p);
            bus(1'b1, `RBAG_OFS_AUXZERO, x);
            bus(1'b1, `RBAG_OFS_TEMPIDX, t);
            bus(1'b1, `RBAG_OFS_BUFSTART, b);
            bus(1'b1, `RBAG_OFS_ACC, q);
        end
    endtask
    task cmd(input [1:0] form, input [1:0] op);
        integer n;
        begin
            bus(1'b1, `RBAG_OFS_CMD, {23'h0, 1'b1, 4'h0, op, form});
            n = 0;
            while (busy !== 1'b0 && n < 20) begin
                @(posedge clk_sys_i);
                #1 n = n + 1;
            end
            if (busy !== 1'b0) begin
                failures = failures + 1;
                summarize;
            end
        end
    endtask
    task s_reset;
        begin
            bus(1'b1, 8'h24, 32'h5a5a5a5a);
            for (a = 0; a <= 8'h24; a = a + 4) rchk(a[7:0], `RBAG_RST_WORD);
        end
    endtask
    task s_postdec;
        begin
            regs(32'h0, 32'h0, 32'h7, 32'h3, 32'h0, 32'h0);
            cmd(`RBAG_FORM_POSTDEC, `RBAG_OP_SET);
            rchk(`RBAG_OFS_ACC, 32'h1);
            rchk(`RBAG_OFS_POINTER, 32'hfffd);
            rchk(`RBAG_OFS_LASTADDR, 32'h0);
        end
    endtask
    task s_indexed;
        begin
            regs(32'h0, 32'h0, 32'h7, 32'hf, 32'h0, 32'hffffffff);
            cmd(`RBAG_FORM_INDEXED, `RBAG_OP_CLEAR);
            rchk(`RBAG_OFS_ACC, 32'hffff7fff);
            rchk(`RBAG_OFS_POINTER, 32'h0);
        end
    endtask
    task s_legacy_pair;
        begin
            regs(32'h1, 32'h19, 32'h5, 32'h9, 32'h0, 32'h40000000);
            cmd(`RBAG_FORM_INDEXED, `RBAG_OP_TESTPAIR);
            rchk(`RBAG_OFS_STATUS0, 32'h1);
            rchk(`RBAG_OFS_LASTADDR, 32'h1f);
            rchk(`RBAG_OFS_POINTER, 32'h19);
        end
    endtask
    task s_brinc;
        begin
            regs(32'h0, 32'h1e, 32'h7, 32'h8, 32'h0, 32'h80000000);
            cmd(`RBAG_FORM_BRINC, `RBAG_OP_TESTPAIR);
            rchk(`RBAG_OFS_STATUS0, 32'h2);
            rchk(`RBAG_OFS_POINTER, {16'h0, rc(16'h1e, 16'h8, 1'b0)});
        end
    endtask
    task s_brdec;
        begin
            regs(32'h1, 32'h6, 32'h4, 32'h9, 32'h0, 32'h40);
            cmd(`RBAG_FORM_BRDEC, `RBAG_OP_TEST);
            rchk(`RBAG_OFS_STATUS0, 32'h3);
            rchk(`RBAG_OFS_POINTER, {16'h0, rc(16'h6, 16'h4, 1'b1)});
        end
    endtask
    task s_circ;
        begin
            regs(32'h2, 32'h3, 32'h7, 32'h5, 32'h10, 32'h0);
            cmd(`RBAG_FORM_BRINC, `RBAG_OP_SET);
            rchk(`RBAG_OFS_ACC, 32'h00080000);
            rchk(`RBAG_OFS_POINTER, 32'h3);
            cmd(`RBAG_FORM_POSTDEC, `RBAG_OP_CLEAR);
            rchk(`RBAG_OFS_ACC, 32'h0);
            rchk(`RBAG_OFS_POINTER, 32'hfffe);
            rchk(`RBAG_OFS_LASTADDR, 32'h13);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        s_reset;
        s_postdec;
        s_indexed;
        s_legacy_pair;
        s_brinc;
        s_brdec;
        s_circ;
        summarize;
    end
endmodule // tb_register_bit_address_generator
